// [include/gpt_pkg.sv]
package gpt_pkg;
  // ==========================================================
  // Register byte offsets; half B sits one word above half A
  localparam int          AW        = 7;
  localparam logic [6:0]  CFG_OFF   = 7'h00;
  localparam logic [6:0]  CTL_OFF   = 7'h04;
  localparam logic [6:0]  IMR_OFF   = 7'h08;
  localparam logic [6:0]  RIS_OFF   = 7'h0c;
  localparam logic [6:0]  MIS_OFF   = 7'h10;
  localparam logic [6:0]  ICR_OFF   = 7'h14;
  localparam logic [6:0]  LOAD_OFF  = 7'h18;
  localparam logic [6:0]  MATCH_OFF = 7'h20;
  localparam logic [6:0]  PRE_OFF   = 7'h28;
  localparam logic [6:0]  PMAT_OFF  = 7'h30;
  localparam logic [6:0]  VAL_OFF   = 7'h38;
  localparam logic [6:0]  SYNC_OFF  = 7'h40;
  localparam logic [6:0]  CAP_OFF   = 7'h44;
  localparam int          HALF_STEP = 4;
  localparam logic [31:0] REG_RST   = 32'h0;
  localparam int          NHALF     = 2;
  // ==========================================================
  // Configuration fields
  localparam int CFG_WID_LSB  = 0;
  localparam int CFG_WID_W    = 2;
  localparam int CFG_MODE_LSB = 4;
  localparam int CFG_MODE_W   = 3;
  localparam int CFG_UP_BIT   = 7;
  localparam int CFG_HALF_SH  = 4;
  // ==========================================================
  // Control fields, repeated per half
  localparam int CTL_EN       = 0;
  localparam int CTL_STALL    = 1;
  localparam int CTL_EDGE_LSB = 2;
  localparam int CTL_EDGE_W   = 2;
  localparam int CTL_TRG      = 4;
  localparam int CTL_INV      = 5;
  localparam int CTL_WOT      = 6;
  localparam int CTL_HALF_SH  = 8;
  localparam logic [1:0] EDGE_POS = 2'h0;
  localparam logic [1:0] EDGE_NEG = 2'h1;
  // ==========================================================
  // Interrupt bits, repeated per half
  localparam int IRQ_TMO     = 0;
  localparam int IRQ_CMT     = 1;
  localparam int IRQ_CEV     = 2;
  localparam int IRQ_MAT     = 3;
  localparam int IRQ_HALF_SH = 4;
  localparam int IRQ_W       = 8;
  // ==========================================================
  // Real time clock source and tick period
  localparam int RTC_HZ     = 32768;
  localparam int RTC_TICK_S = 1;
  typedef enum logic [1:0] {GPT_FULL, GPT_RTC, GPT_SPLIT} gpt_width_t;
  typedef enum logic [2:0] {GPT_ONESHOT, GPT_PERIODIC, GPT_CAPCNT, GPT_CAPTIM,
                            GPT_PWM} gpt_mode_t;
endpackage

// [verilog/gpt_core.sv]
`timescale 1ns/100ps
// ==========================================================
// Counter core: up or down, one-shot or periodic
module gpt_core #(
  parameter int W = 32
) (
  input  wire logic         ref_clk_i,
  input  wire logic         reset_i,
  input  wire logic         start_i,     // Load start value and run
  input  wire logic         stop_i,      // Level: halt counting
  input  wire logic         step_i,      // Advance by one
  input  wire logic         up_i,        // Count direction
  input  wire logic         periodic_i,  // Reload at end
  input  wire logic [W-1:0] load_i,      // Load value
  output logic      [W-1:0] cnt_o,       // Current count
  output logic              run_o,       // Counting
  output logic              tmo_o        // Pulse at end of count
);
  logic [W-1:0] start_v;  // Start value for direction
  logic         at_end;   // Terminal count reached
  logic         fin;      // Step taken at terminal count this cycle

  assign start_v = up_i ? '0 : load_i;
  assign at_end  = up_i ? (cnt_o == load_i) : (cnt_o == '0);
  assign fin     = run_o && step_i && at_end && !stop_i && !start_i;

  // Count and run state
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cnt_o <= '0;
      run_o <= 1'b0;
    end else if (stop_i) begin
      run_o <= 1'b0;
    end else if (start_i) begin
      cnt_o <= start_v;
      run_o <= 1'b1;
    end else if (fin) begin
      if (periodic_i) begin
        cnt_o <= start_v;
      end
      run_o <= periodic_i;
    end else if (run_o && step_i) begin
      cnt_o <= up_i ? cnt_o + 1'b1 : cnt_o - 1'b1;
    end
  end

  // Timeout pulse, one cycle after the final step
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      tmo_o <= 1'b0;
    end else begin
      tmo_o <= fin;
    end
  end

  oneshot_stop_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (fin && !periodic_i) |=> (tmo_o && !run_o && $stable(cnt_o)))
    else $error("one-shot counter did not stop at its end");

  periodic_rld_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (fin && periodic_i) |=> (tmo_o && run_o && cnt_o == $past(start_v)))
    else $error("periodic counter did not reload");
endmodule

// [verilog/gpt_timer.sv]
// Our own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/100ps
// Operation
// - two halves, independent or joined
// - halves 16 or 32 bits wide
// - joined timer uses first half controls
// - one-shot stops at zero or load
// - periodic reloads at end and continues
// - seconds clock only when joined
// - capture and PWM only when split
// - capture measures time or counts edges
// - edge select: rising, falling or both
// - PWM turns capture pin into output
// - inversion, trigger outputs, stall choice
// - interrupts on capture and event count
// - interrupts on timeout and match
// - synchronize command restarts chosen counters
// - load, prescale, match values read back
// - per-source enable, clear, raw or masked
// - configure write disables the module
// - stall option stops counting in debug
// - inversion makes PWM active low
// - wait-on-trigger holds start until trigger
module gpt_timer #(
  parameter int HW      = 16,                                        // Half width
  parameter int PW      = 8,                                         // Prescaler width
  parameter int RTC_DIV = gpt_pkg::RTC_HZ * gpt_pkg::RTC_TICK_S      // Source edges per tick
) (
  input  wire logic                  ref_clk_i,
  input  wire logic                  reset_i,
  input  wire logic [gpt_pkg::AW-1:0] avs_address_i,
  input  wire logic                  avs_read_i,
  input  wire logic                  avs_write_i,
  input  wire logic [31:0]           avs_writedata_i,
  input  wire logic [3:0]            avs_byteenable_i,
  output logic      [31:0]           avs_readdata_o,
  output logic                       avs_waitrequest_o,
  input  wire logic [1:0]            ccp_i,        // Capture pins, per half
  output logic      [1:0]            ccp_o,        // PWM drive
  output logic      [1:0]            ccp_oe_n_o,   // Low while driving
  input  wire logic                  rtc_clk_i,    // Slow source, sampled
  input  wire logic                  debug_halt_i, // Processor halted
  input  wire logic                  trig_in_i,    // Previous timer timeout
  input  wire logic [1:0]            sync_i,       // Synchronize command in
  output logic      [1:0]            trig_o,       // Trigger outputs
  output logic                       irq_o
);
  // joined width is twice the half
  localparam int FW = 2 * HW;                 // Joined width
  localparam int RW = $clog2(RTC_DIV);        // Divider width

  // ==========================================================
  // Declarations
  logic [31:0]              cfg_q;            // Mode configuration
  logic [31:0]              ctl_q;            // Control bits
  logic [gpt_pkg::IRQ_W-1:0] imr_q;           // Interrupt enables
  logic [gpt_pkg::IRQ_W-1:0] ris_q;           // Raw status
  logic [gpt_pkg::IRQ_W-1:0] ev;              // Events this cycle
  logic [gpt_pkg::IRQ_W-1:0] clr;             // Clear mask from software
  logic [HW-1:0]            load_q  [2];
  logic [HW-1:0]            match_q [2];
  logic [HW-1:0]            cap_q   [2];      // Captured time stamps
  logic [PW-1:0]            pre_q   [2];
  logic [PW-1:0]            pmat_q  [2];
  logic [PW-1:0]            pcnt_q  [2];      // Prescaler count
  logic [FW-1:0]            cnt     [2];
  logic [FW-1:0]            lval    [2];
  logic [FW-1:0]            mval    [2];
  logic [1:0]               run, tmo, en, en_q, arm_q, start, step, stepd_q;
  logic [1:0]               halt, edge_ev, prev_q, trg_src, pwm_act, inv, syncw;
  logic [1:0]               up, per, timer, pwm;
  gpt_pkg::gpt_mode_t       md      [2];
  gpt_pkg::gpt_width_t      wid;
  logic                     split, rtc, wr_en, rtc_prev_q, sec_q, irq_src;
  logic [RW-1:0]            rdiv_q;           // Seconds divider
  logic [31:0]              rd;               // Read mux

  // ==========================================================
  // Helpers
  // Byte-lane merge for partial writes
  function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] n,
                                      input logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = n[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Write hit on a per-half register
  function automatic logic hit(input logic [6:0] base, input int h);
    return wr_en && (avs_address_i == 7'(base + h * gpt_pkg::HALF_STEP));
  endfunction

  // Edge select decode
  // edge choice
  function automatic logic edge_hit(input logic cur, input logic prv,
                                    input logic [1:0] sel);
    if (sel == gpt_pkg::EDGE_POS) begin
      return cur && !prv;
    end else if (sel == gpt_pkg::EDGE_NEG) begin
      return !cur && prv;
    end
    return cur != prv;
  endfunction

  // ==========================================================
  // Mode decode
  assign wid   = gpt_pkg::gpt_width_t'(cfg_q[gpt_pkg::CFG_WID_LSB +: gpt_pkg::CFG_WID_W]);
  assign split = (wid == gpt_pkg::GPT_SPLIT);
  assign rtc   = (wid == gpt_pkg::GPT_RTC);
  assign wr_en = avs_write_i && !avs_waitrequest_o;
  assign trg_src[0] = trig_in_i;
  assign trg_src[1] = tmo[0];
  assign lval[0] = split ? FW'(load_q[0]) : {load_q[1], load_q[0]};
  assign mval[0] = split ? FW'(match_q[0]) : {match_q[1], match_q[0]};
  assign lval[1] = FW'(load_q[1]);
  assign mval[1] = FW'(match_q[1]);

  // Per-half mode, enable and step
  always_comb begin
    for (int h = 0; h < gpt_pkg::NHALF; h++) begin
      md[h] = gpt_pkg::gpt_mode_t'(cfg_q[gpt_pkg::CFG_MODE_LSB + h * gpt_pkg::CFG_HALF_SH
                                         +: gpt_pkg::CFG_MODE_W]);
      if (rtc) begin
        md[h] = gpt_pkg::GPT_PERIODIC;
      end else if (!split && md[h] != gpt_pkg::GPT_PERIODIC) begin
        md[h] = gpt_pkg::GPT_ONESHOT;
      end
      timer[h] = (md[h] == gpt_pkg::GPT_ONESHOT) || (md[h] == gpt_pkg::GPT_PERIODIC);
      pwm[h]   = (md[h] == gpt_pkg::GPT_PWM);
      per[h]   = (md[h] != gpt_pkg::GPT_ONESHOT);
      up[h]    = rtc || (!pwm[h] && cfg_q[gpt_pkg::CFG_UP_BIT + h * gpt_pkg::CFG_HALF_SH]);
      // joined timer uses first half controls
      en[h]    = ctl_q[gpt_pkg::CTL_EN + h * gpt_pkg::CTL_HALF_SH] && (h == 0 || split);
      inv[h]   = ctl_q[gpt_pkg::CTL_INV + h * gpt_pkg::CTL_HALF_SH];
      halt[h]  = debug_halt_i && ctl_q[gpt_pkg::CTL_STALL + h * gpt_pkg::CTL_HALF_SH];
      edge_ev[h] = edge_hit(ccp_i[h], prev_q[h],
                            ctl_q[gpt_pkg::CTL_EDGE_LSB + h * gpt_pkg::CTL_HALF_SH
                                  +: gpt_pkg::CTL_EDGE_W]);
      if (rtc) begin
        step[h] = sec_q;
      end else if (!split) begin
        step[h] = 1'b1;
      end else if (md[h] == gpt_pkg::GPT_CAPCNT) begin
        step[h] = edge_ev[h];
      end else begin
        step[h] = (pcnt_q[h] == pre_q[h]);
      end
      step[h]  = step[h] && !halt[h];
      syncw[h] = (wr_en && avs_address_i == gpt_pkg::SYNC_OFF && avs_writedata_i[h]) || sync_i[h];
      start[h] = en[h] && (syncw[h] || (arm_q[h] && trg_src[h]) ||
                 (!en_q[h] && !ctl_q[gpt_pkg::CTL_WOT + h * gpt_pkg::CTL_HALF_SH]));
      pwm_act[h] = cnt[h] > mval[h];
    end
  end

  // ==========================================================
  // Counter cores
  for (genvar g = 0; g < gpt_pkg::NHALF; g++) begin : g_core
    gpt_core #(.W(FW)) u_core (
      .ref_clk_i  (ref_clk_i),
      .reset_i    (reset_i),
      .start_i    (start[g]),
      .stop_i     (!en[g]),
      .step_i     (step[g]),
      .up_i       (up[g]),
      .periodic_i (per[g]),
      .load_i     (lval[g]),
      .cnt_o      (cnt[g]),
      .run_o      (run[g]),
      .tmo_o      (tmo[g])
    );
  end

  // ==========================================================
  // Events and status
  always_comb begin
    ev  = '0;
    clr = (wr_en && avs_address_i == gpt_pkg::ICR_OFF) ?
          avs_writedata_i[gpt_pkg::IRQ_W-1:0] : '0;
    for (int h = 0; h < gpt_pkg::NHALF; h++) begin
      ev[h * gpt_pkg::IRQ_HALF_SH + gpt_pkg::IRQ_TMO] = tmo[h] && timer[h];
      ev[h * gpt_pkg::IRQ_HALF_SH + gpt_pkg::IRQ_MAT] = run[h] && timer[h] &&
        (cnt[h] == mval[h]) && (split ? (pcnt_q[h] == pmat_q[h]) : stepd_q[h]);
      ev[h * gpt_pkg::IRQ_HALF_SH + gpt_pkg::IRQ_CMT] = tmo[h] && md[h] == gpt_pkg::GPT_CAPCNT;
      ev[h * gpt_pkg::IRQ_HALF_SH + gpt_pkg::IRQ_CEV] = edge_ev[h] && run[h] &&
        (md[h] == gpt_pkg::GPT_CAPCNT || md[h] == gpt_pkg::GPT_CAPTIM);
    end
  end
  assign irq_src = |(ris_q & imr_q);

  // Raw status: a new event wins over a clear in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ris_q <= '0;
      irq_o <= 1'b0;
    end else begin
      ris_q <= (ris_q & ~clr) | ev;
      // only enabled sources drive the line
      irq_o <= irq_src;
    end
  end

  // ==========================================================
  // Configuration and control registers
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cfg_q <= gpt_pkg::REG_RST;
      ctl_q <= gpt_pkg::REG_RST;
      imr_q <= '0;
    end else if (wr_en) begin
      if (avs_address_i == gpt_pkg::CFG_OFF) begin
        cfg_q <= mrg(cfg_q, avs_writedata_i, avs_byteenable_i);
        ctl_q[gpt_pkg::CTL_EN] <= 1'b0;
        ctl_q[gpt_pkg::CTL_EN + gpt_pkg::CTL_HALF_SH] <= 1'b0;
      end
      if (avs_address_i == gpt_pkg::CTL_OFF) begin
        ctl_q <= mrg(ctl_q, avs_writedata_i, avs_byteenable_i);
      end
      if (avs_address_i == gpt_pkg::IMR_OFF) begin
        imr_q <= avs_writedata_i[gpt_pkg::IRQ_W-1:0];
      end
    end
  end

  // Value registers, per half
  always_ff @(posedge ref_clk_i) begin
    for (int h = 0; h < gpt_pkg::NHALF; h++) begin
      if (reset_i) begin
        load_q[h]  <= '0;
        match_q[h] <= '0;
        pre_q[h]   <= '0;
        pmat_q[h]  <= '0;
      end else begin
        if (hit(gpt_pkg::LOAD_OFF, h)) begin
          load_q[h] <= HW'(mrg(32'(load_q[h]), avs_writedata_i, avs_byteenable_i));
        end
        if (hit(gpt_pkg::MATCH_OFF, h)) begin
          match_q[h] <= HW'(mrg(32'(match_q[h]), avs_writedata_i, avs_byteenable_i));
        end
        if (hit(gpt_pkg::PRE_OFF, h)) begin
          pre_q[h] <= PW'(mrg(32'(pre_q[h]), avs_writedata_i, avs_byteenable_i));
        end
        if (hit(gpt_pkg::PMAT_OFF, h)) begin
          pmat_q[h] <= PW'(mrg(32'(pmat_q[h]), avs_writedata_i, avs_byteenable_i));
        end
      end
    end
  end

  // ==========================================================
  // Per-half sequencing: prescaler, trigger arm, capture, pins
  always_ff @(posedge ref_clk_i) begin
    for (int h = 0; h < gpt_pkg::NHALF; h++) begin
      if (reset_i) begin
        pcnt_q[h]     <= '0;
        en_q[h]       <= 1'b0;
        arm_q[h]      <= 1'b0;
        stepd_q[h]    <= 1'b0;
        prev_q[h]     <= 1'b0;
        cap_q[h]      <= '0;
        ccp_o[h]      <= 1'b0;
        ccp_oe_n_o[h] <= 1'b1;
        trig_o[h]     <= 1'b0;
      end else begin
        en_q[h]    <= en[h];
        stepd_q[h] <= step[h] && run[h];
        prev_q[h]  <= ccp_i[h];
        if (start[h] || !split) begin
          pcnt_q[h] <= '0;
        end else if (run[h] && !halt[h]) begin
          pcnt_q[h] <= (pcnt_q[h] == pre_q[h]) ? '0 : pcnt_q[h] + 1'b1;
        end
        if (!en[h] || start[h]) begin
          arm_q[h] <= 1'b0;
        end else if (!en_q[h] && ctl_q[gpt_pkg::CTL_WOT + h * gpt_pkg::CTL_HALF_SH]) begin
          arm_q[h] <= 1'b1;
        end
        if (edge_ev[h] && run[h] && md[h] == gpt_pkg::GPT_CAPTIM) begin
          cap_q[h] <= cnt[h][HW-1:0];
        end
        // pin drives in PWM, level inverted when inv set
        ccp_o[h]      <= pwm[h] && (pwm_act[h] ^ inv[h]);
        ccp_oe_n_o[h] <= !pwm[h];
        trig_o[h]     <= tmo[h] && ctl_q[gpt_pkg::CTL_TRG + h * gpt_pkg::CTL_HALF_SH];
      end
    end
  end

  // ==========================================================
  // Seconds divider, counts rising edges of the slow source
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rtc_prev_q <= 1'b0;
      rdiv_q     <= '0;
      sec_q      <= 1'b0;
    end else begin
      rtc_prev_q <= rtc_clk_i;
      sec_q      <= 1'b0;
      // divide to one tick per second
      if (!(rtc && en[0])) begin
        rdiv_q <= '0;
      end else if (rtc_clk_i && !rtc_prev_q) begin
        if (rdiv_q == RW'(RTC_DIV - 1)) begin
          rdiv_q <= '0;
          sec_q  <= 1'b1;
        end else begin
          rdiv_q <= rdiv_q + 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Avalon slave: one wait state, unmapped reads return zero
  always_comb begin
    unique case (avs_address_i)
      gpt_pkg::CFG_OFF:   rd = cfg_q;
      gpt_pkg::CTL_OFF:   rd = ctl_q;
      gpt_pkg::IMR_OFF:   rd = 32'(imr_q);
      gpt_pkg::RIS_OFF:   rd = 32'(ris_q);
      gpt_pkg::MIS_OFF:   rd = 32'(ris_q & imr_q);
      gpt_pkg::LOAD_OFF:  rd = 32'(load_q[0]);
      gpt_pkg::MATCH_OFF: rd = 32'(match_q[0]);
      gpt_pkg::PRE_OFF:   rd = 32'(pre_q[0]);
      gpt_pkg::PMAT_OFF:  rd = 32'(pmat_q[0]);
      gpt_pkg::CAP_OFF:   rd = 32'(cap_q[0]);
      gpt_pkg::VAL_OFF:   rd = 32'(cnt[0]);
      7'(gpt_pkg::VAL_OFF + gpt_pkg::HALF_STEP):   rd = split ? 32'(cnt[1]) : 32'(cnt[0] >> HW);
      7'(gpt_pkg::LOAD_OFF + gpt_pkg::HALF_STEP):  rd = 32'(load_q[1]);
      7'(gpt_pkg::MATCH_OFF + gpt_pkg::HALF_STEP): rd = 32'(match_q[1]);
      7'(gpt_pkg::PRE_OFF + gpt_pkg::HALF_STEP):   rd = 32'(pre_q[1]);
      7'(gpt_pkg::PMAT_OFF + gpt_pkg::HALF_STEP):  rd = 32'(pmat_q[1]);
      7'(gpt_pkg::CAP_OFF + gpt_pkg::HALF_STEP):   rd = 32'(cap_q[1]);
      default:            rd = '0;
    endcase
  end

  // Waitrequest drops one cycle after the request, then rises again
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= '0;
    end else if (!avs_waitrequest_o) begin
      avs_waitrequest_o <= 1'b1;
    end else if (avs_read_i || avs_write_i) begin
      avs_waitrequest_o <= 1'b0;
      avs_readdata_o    <= rd;
    end
  end

  // ==========================================================
  // Checks
  cfg_dis_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (wr_en && avs_address_i == gpt_pkg::CFG_OFF) |=> (en == 2'h0))
    else $error("module still enabled after configure");

  stall_hold_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (halt[0] && en[0] && !start[0]) |=> $stable(cnt[0]))
    else $error("counter moved while stalled");

  pwm_drive_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    pwm[0] |=> !ccp_oe_n_o[0])
    else $error("pin not driven in PWM mode");

  pwm_level_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    pwm[0] |=> (ccp_o[0] == ($past(pwm_act[0]) ^ $past(inv[0]))))
    else $error("PWM level wrong for inversion");

  ris_hold_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (ris_q[gpt_pkg::IRQ_TMO] && !clr[gpt_pkg::IRQ_TMO]) |=> ris_q[gpt_pkg::IRQ_TMO])
    else $error("raw status lost without clear");

  irq_gate_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    1'b1 |=> (irq_o == $past(irq_src)))
    else $error("interrupt line does not follow masked status");
endmodule

// [tb/gpt_pin_model.sv]
`timescale 1ns/100ps
// ==========================================================
// Far side: capture pin pulser and free slow clock
module gpt_pin_model (
  input  wire logic ref_clk_i,
  input  wire logic pulse_i,   // Request one pin pulse
  output logic      pin_o,     // Level on the capture pin
  output logic      rtc_clk_o  // Slow source
);
  logic [1:0] hold_q = 2'h0;   // Pulse cycles left
  // slow source
  // Runs free at about 32768 Hz, unrelated in phase to the bus clock
  initial rtc_clk_o = 1'b0;
  always #15259 rtc_clk_o = ~rtc_clk_o;
  // Three cycles high per request; idle low so each pulse is two edges
  always_ff @(posedge ref_clk_i) begin
    if (pulse_i) hold_q <= 2'h3;
    else if (hold_q != 2'h0) hold_q <= hold_q - 2'h1;
  end
  assign pin_o = (hold_q != 2'h0);
endmodule

// [tb/gpt_timer_bench.sv]
`timescale 1ns/100ps
// ==========================================================
// Bench: bus tasks, timer modes, pin traffic
module gpt_timer_bench;
  logic        ref_clk_i = 0, reset_i = 1, rd = 0, wr = 0, pulse = 0;
  logic        pin, rtc, irq, wt;      // Far side and answers
  logic [6:0]  adr = 0;                // Byte address
  logic [31:0] wd = 0, rdat, rdo, v;   // Bus data
  logic [1:0]  pwm, oe_n, cin, trg;    // Pin wires
  int          err_count = 0, checks_done = 0, seed = 32'h8bd889b4;
  int          h[2], m, e;             // High counts, loop indices
  logic        dbg = 0, tin = 0;       // Debug halt, chain trigger in
  logic [1:0]  sy = 0;                 // Synchronize pulses
  int          tn = 0;                 // Trigger pulses seen on half A
  always #50 ref_clk_i = ~ref_clk_i;
  // Count trigger pulses; each lasts one cycle so a sampled count is exact
  always @(posedge ref_clk_i) if (trg[0] === 1'b1) tn++;
  // Wire level: the half drives its pin only while its enable is low
  assign cin = {oe_n[1] ? pin : pwm[1], oe_n[0] ? pin : pwm[0]};
  gpt_timer #(.HW(16), .PW(8), .RTC_DIV(4)) u_gpt_timer (.ref_clk_i(ref_clk_i),
    .reset_i(reset_i), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(4'hf), .avs_readdata_o(rdo),
    .avs_waitrequest_o(wt), .ccp_i(cin), .ccp_o(pwm), .ccp_oe_n_o(oe_n),
    .rtc_clk_i(rtc), .debug_halt_i(dbg), .trig_in_i(tin), .sync_i(sy),
    .trig_o(trg), .irq_o(irq));
  gpt_pin_model u_gpt_pin_model (.ref_clk_i(ref_clk_i), .pulse_i(pulse), .pin_o(pin),
    .rtc_clk_o(rtc));
  // Counts line, verdict, end of run
  task results;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x) begin
      err_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  // One transfer; held until waitrequest is sampled low, released after
  task bus(input logic w, input logic [6:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk_i);
    adr <= a; wd <= d; wr <= w; rd <= !w;
    for (k = 0; k < 20; k++) begin
      @(posedge ref_clk_i);
      if (wt === 1'b0) break;
    end
    rdat = rdo;
    wr <= 1'b0; rd <= 1'b0;
    if (k == 20) begin err_count++; results; end
  endtask
  // Bounded wait for the interrupt line to reach a level
  task wait_irq(input logic x);
    int k;
    for (k = 0; k < 6000 && irq !== x; k++) @(posedge ref_clk_i);
    if (irq !== x) begin err_count++; results; end
  endtask
  initial begin
    repeat (2) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    bus(0, gpt_pkg::CFG_OFF, 0); chk(rdat, gpt_pkg::REG_RST); // reset value
    bus(0, 7'h7c, 0); chk(rdat, 32'h0); // unmapped
    // Load, match, prescale, prescale-match of both halves read back
    for (m = 0; m < 8; m++) begin
      v = $random(seed) & ((m < 4) ? 32'hffff : 32'hff);
      bus(1, 7'h18 + 4 * m, v); bus(0, 7'h18 + 4 * m, 0); chk(rdat, v); // readback
    end
    // Full width: one-shot, periodic, seconds clock
    for (m = 0; m < 3; m++) begin
      bus(1, gpt_pkg::CFG_OFF, (m == 0) ? 0 : (m == 1) ? 32'h10 : 32'h1);
      bus(1, gpt_pkg::LOAD_OFF, (m == 2) ? 2 : 8 + ($random(seed) & 7));
      bus(1, gpt_pkg::LOAD_OFF + 4, 0); bus(1, gpt_pkg::IMR_OFF, 1); bus(1, gpt_pkg::CTL_OFF, 1);
      wait_irq(1'b1);
      bus(0, gpt_pkg::MIS_OFF, 0); chk(rdat[0], 1'b1); // masked timeout
      if (m == 0) begin bus(0, gpt_pkg::VAL_OFF, 0); chk(rdat, 32'h0); end // stays at zero
      bus(1, gpt_pkg::IMR_OFF, 0); wait_irq(1'b0);
      bus(0, gpt_pkg::RIS_OFF, 0); chk(rdat[0], 1'b1); // sticky raw
      bus(1, gpt_pkg::ICR_OFF, 1);
      // Seconds mode wraps every three ticks of four slow edges, about 3660 cycles
      repeat ((m == 2) ? 4000 : 40) @(posedge ref_clk_i);
      bus(0, gpt_pkg::RIS_OFF, 0); chk(rdat[0], m != 0); // stop or reload
      bus(1, gpt_pkg::CFG_OFF, 0); bus(0, gpt_pkg::CTL_OFF, 0); chk(rdat, 32'h0);
    end
    // Split PWM on first half, plain then inverted
    bus(1, gpt_pkg::CFG_OFF, 32'h42); bus(1, gpt_pkg::LOAD_OFF, 10);
    bus(1, gpt_pkg::MATCH_OFF, 3); bus(1, gpt_pkg::PRE_OFF, 0);
    for (m = 0; m < 2; m++) begin
      bus(1, gpt_pkg::CTL_OFF, 1 | (m << 5));
      repeat (4) @(posedge ref_clk_i);
      chk(oe_n, 2'b10); // pin turns output
      h[m] = 0;
      repeat (110) @(posedge ref_clk_i) h[m] += pwm[0];
    end
    chk(h[1] > 0 && h[1] < h[0] && h[0] < 110, 1); // inversion
    bus(1, gpt_pkg::CFG_OFF, 0); repeat (3) @(posedge ref_clk_i);
    chk(oe_n, 2'b11); // no pin drive when joined
    // Edge count for rising, falling and both edges
    for (e = 0; e < 3; e++) begin
      // Count reached on the step taken at zero, so load 3 needs four edges
      bus(1, gpt_pkg::CFG_OFF, 32'h22); bus(1, gpt_pkg::LOAD_OFF, 3);
      bus(1, gpt_pkg::ICR_OFF, 32'hff); bus(1, gpt_pkg::CTL_OFF, 1 | (e << 2));
      for (m = 0; m < ((e == 2) ? 2 : 4); m++) begin
        if (m == ((e == 2) ? 1 : 3)) begin
          bus(0, gpt_pkg::RIS_OFF, 0); chk(rdat[2:1], 2'b10); // not yet
        end
        @(posedge ref_clk_i) pulse <= 1'b1;
        @(posedge ref_clk_i) pulse <= 1'b0;
        repeat (8) @(posedge ref_clk_i);
      end
      bus(0, gpt_pkg::RIS_OFF, 0); chk(rdat[1], 1'b1); // count reached
    end
    // Wait-on-trigger with stall and trigger out: held, started, frozen, timed out
    bus(1, gpt_pkg::CFG_OFF, 0); bus(1, gpt_pkg::LOAD_OFF, 50);
    bus(1, gpt_pkg::ICR_OFF, 32'hff); bus(1, gpt_pkg::CTL_OFF, 32'h53);
    repeat (80) @(posedge ref_clk_i);
    bus(0, gpt_pkg::RIS_OFF, 0); chk(rdat[0], 1'b0); // held until trigger
    @(posedge ref_clk_i) tin <= 1'b1;
    @(posedge ref_clk_i) begin
      tin <= 1'b0;
      dbg <= 1'b1;
    end
    repeat (20) @(posedge ref_clk_i);
    bus(0, gpt_pkg::VAL_OFF, 0); chk(rdat, 32'd50); // started, then frozen
    dbg <= 1'b0;
    bus(1, gpt_pkg::IMR_OFF, 1); wait_irq(1'b1);
    chk(tn, 1); // one trigger pulse
    // External synchronize restarts a running periodic count from its load
    bus(1, gpt_pkg::CFG_OFF, 32'h10); bus(1, gpt_pkg::LOAD_OFF, 200);
    bus(1, gpt_pkg::CTL_OFF, 1); repeat (60) @(posedge ref_clk_i);
    @(posedge ref_clk_i) sy <= 2'h1;
    @(posedge ref_clk_i) sy <= 2'h0;
    bus(0, gpt_pkg::VAL_OFF, 0); chk(rdat > 32'd190 && rdat <= 32'd200, 1'b1); // restart
    results;
  end
endmodule
